// [hdl/gpio_pin_control.sv]
`timescale 1ns/1ps
`include "gpio_pin_control_params.svh"

module gpio_pin_control #(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sources of the alternate pin functions
  input wire logic irq_source,
  input wire logic sync_source,
  input wire logic antenna_drives_out,
  input wire logic antenna_two_pin_mode,
  // Antenna control input recovered from pin 0
  output logic antenna_control_input,
  // Device pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe
);

  // ***********************************************************
  // Address decode
  // ***********************************************************

  // Only word-aligned addresses of the four registers map
  function automatic gpio_pin_control_pkg::reg_sel_t decode_sel(
    input logic [31:0] addr
  );
    gpio_pin_control_pkg::reg_sel_t sel;
    sel = gpio_pin_control_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[31:2] == 30'(`GPC_IDX_FUNC_SEL))
        sel = gpio_pin_control_pkg::SEL_FUNC;
      else if (addr[31:2] == 30'(`GPC_IDX_OUT_VAL))
        sel = gpio_pin_control_pkg::SEL_OUT;
      else if (addr[31:2] == 30'(`GPC_IDX_DIRECTION))
        sel = gpio_pin_control_pkg::SEL_DIR;
      else if (addr[31:2] == 30'(`GPC_IDX_IN_VAL))
        sel = gpio_pin_control_pkg::SEL_IN;
    end
    return sel;
  endfunction : decode_sel

  // ***********************************************************
  // Registers and bus state
  // ***********************************************************
  gpio_pin_control_pkg::byte_reg_t pin_function_select;
  gpio_pin_control_pkg::byte_reg_t pin_output_value;
  gpio_pin_control_pkg::byte_reg_t pin_direction;
  gpio_pin_control_pkg::byte_reg_t pin_input_value;
  gpio_pin_control_pkg::reg_sel_t wr_sel;
  logic wr_pending;
  logic [PIN_COUNT-1:0] pin_level;

  // Address phase qualification
  wire addr_phase = hsel && hready && htrans[`GPC_TRANS_ACTIVE_BIT];
  wire wr_start = addr_phase && hwrite;
  wire rd_start = addr_phase && !hwrite;
  wire gpio_pin_control_pkg::reg_sel_t addr_sel = decode_sel(haddr);

  // Data phase write strobes per register
  wire wr_func = wr_pending && wr_sel == gpio_pin_control_pkg::SEL_FUNC;
  wire wr_out = wr_pending && wr_sel == gpio_pin_control_pkg::SEL_OUT;
  wire wr_dir = wr_pending && wr_sel == gpio_pin_control_pkg::SEL_DIR;

  // Next register values; reserved select bits never store
  // reserved bits masked
  wire [7:0] next_function_select = wr_func ?
    (hwdata[7:0] & `GPC_FUNC_SEL_MASK) : pin_function_select;
  wire [7:0] next_output_value = wr_out ? hwdata[7:0] : pin_output_value;
  wire [7:0] next_direction = wr_dir ? hwdata[7:0] : pin_direction;

  // Read mux sees pending write so back-to-back read is current
  wire [7:0] read_byte =
    (addr_sel == gpio_pin_control_pkg::SEL_FUNC) ? next_function_select :
    (addr_sel == gpio_pin_control_pkg::SEL_OUT) ? next_output_value :
    (addr_sel == gpio_pin_control_pkg::SEL_DIR) ? next_direction :
    (addr_sel == gpio_pin_control_pkg::SEL_IN) ? pin_input_value :
    8'h00;
  wire [31:0] next_hrdata = rd_start ? {24'h00_0000, read_byte} :
    `GPC_RDATA_ZERO;

  // Capture the address phase; writes land one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_sel <= gpio_pin_control_pkg::SEL_NONE;
      hrdata <= `GPC_RDATA_ZERO;
    end else begin
      wr_pending <= wr_start;
      wr_sel <= addr_sel;
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states, always OKAY; flops keep outputs registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Software-visible configuration registers
  // register reset and write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_function_select <= `GPC_RST_FUNC_SEL;
      pin_output_value <= `GPC_RST_OUT_VAL;
      pin_direction <= `GPC_RST_DIRECTION;
    end else begin
      pin_function_select <= next_function_select;
      pin_output_value <= next_output_value;
      pin_direction <= next_direction;
    end
  end

  // ***********************************************************
  // Pin sampling
  // ***********************************************************
  pin_level_sync #(
    .WIDTH(PIN_COUNT)
  ) i_pin_level_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_level(pin_in),
    .sync_level(pin_level)
  );

  // Input register; slot 1 is the antenna direction pin and reads zero
  // pin level capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_input_value <= 8'h00;
    end else begin
      pin_input_value <= pin_level[7:0] & `GPC_PIN_USABLE_MASK;
    end
  end

  // ***********************************************************
  // Pin drive
  // ***********************************************************
  wire pin7_role_select = pin_function_select[`GPC_BIT_PIN7_ROLE];
  wire pin6_pin5_role_select = pin_function_select[`GPC_BIT_PIN65_ROLE];

  // Plain GPIO drive: direction 0 means output
  // direction sets enable
  wire [PIN_COUNT-1:0] gp_oe = ~pin_direction[PIN_COUNT-1:0];
  wire [PIN_COUNT-1:0] gp_val = pin_output_value[PIN_COUNT-1:0];

  logic [PIN_COUNT-1:0] next_pin_oe;
  logic [PIN_COUNT-1:0] next_pin_out;

  // Alternate functions override GPIO bits per pin
  always_comb begin
    next_pin_oe = gp_oe;
    next_pin_out = gp_val;
    if (pin7_role_select) begin
      next_pin_oe[`GPC_PIN_SEVEN] = 1'b1;
      next_pin_out[`GPC_PIN_SEVEN] = irq_source;
    end
    if (pin6_pin5_role_select) begin
      next_pin_oe[`GPC_PIN_SIX] = 1'b0;
      next_pin_out[`GPC_PIN_SIX] = 1'b0;
      next_pin_oe[`GPC_PIN_FIVE] = 1'b1;
      next_pin_out[`GPC_PIN_FIVE] = sync_source;
    end
    next_pin_oe[`GPC_PIN_ANT_DIR] = 1'b1;
    next_pin_out[`GPC_PIN_ANT_DIR] = antenna_drives_out;
    if (antenna_two_pin_mode) begin
      next_pin_oe[`GPC_PIN_ZERO] = 1'b0;
      next_pin_out[`GPC_PIN_ZERO] = 1'b0;
    end
  end

  // Registered pin drive avoids glitches on board nets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe <= '0;
      pin_out <= '0;
      antenna_control_input <= 1'b0;
    end else begin
      pin_oe <= next_pin_oe;
      pin_out <= next_pin_out;
      antenna_control_input <= antenna_two_pin_mode &&
        pin_level[`GPC_PIN_ZERO];
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  sequence s_rd_func;
    rd_start && addr_sel == gpio_pin_control_pkg::SEL_FUNC;
  endsequence

  sequence s_rd_in;
    rd_start && addr_sel == gpio_pin_control_pkg::SEL_IN;
  endsequence

  sequence s_wr_out;
    wr_start && addr_sel == gpio_pin_control_pkg::SEL_OUT ##1 1'b1;
  endsequence

  property p_pin7_irq;
    @(posedge hclk) disable iff (!hresetn)
    pin7_role_select |=> pin_oe[7] && pin_out[7] == $past(irq_source);
  endproperty
  a_pin7_irq: assert property (p_pin7_irq)
    else $error("pin 7 not driving interrupt");

  property p_pin5_sync;
    @(posedge hclk) disable iff (!hresetn)
    pin6_pin5_role_select |=> pin_oe[5] && !pin_oe[6] &&
      pin_out[5] == $past(sync_source);
  endproperty
  a_pin5_sync: assert property (p_pin5_sync)
    else $error("pin 5 or 6 wrong in sync role");

  property p_func_reserved;
    @(posedge hclk) disable iff (!hresetn)
    s_rd_func |=> hrdata[5:0] == 6'h00 && hrdata[31:8] == 24'h00_0000;
  endproperty
  a_func_reserved: assert property (p_func_reserved)
    else $error("reserved select bits read nonzero");

  property p_ant_dir;
    @(posedge hclk) disable iff (!hresetn)
    // Start only once reset is sampled high: outputs lag release by one edge
    hresetn |=> pin_oe[1] && pin_out[1] == $past(antenna_drives_out);
  endproperty
  a_ant_dir: assert property (p_ant_dir)
    else $error("pin 1 not showing antenna direction");

  property p_pin0_input;
    @(posedge hclk) disable iff (!hresetn)
    antenna_two_pin_mode |=> !pin_oe[0];
  endproperty
  a_pin0_input: assert property (p_pin0_input)
    else $error("pin 0 driven in two-pin mode");

  property p_out_write;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_out |=> pin_output_value == $past(hwdata[7:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output value write lost");

  property p_gpio_drive;
    @(posedge hclk) disable iff (!hresetn)
    !pin_direction[3] |=> pin_oe[3] &&
      pin_out[3] == $past(pin_output_value[3]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("pin 3 not driving its value");

  property p_pin0_gpio;
    @(posedge hclk) disable iff (!hresetn)
    !antenna_two_pin_mode |=> pin_oe[0] == !$past(pin_direction[0]);
  endproperty
  a_pin0_gpio: assert property (p_pin0_gpio)
    else $error("pin 0 ignores its direction bit");

  property p_in_read;
    @(posedge hclk) disable iff (!hresetn)
    s_rd_in |=> !hrdata[1] && hrdata[7] == $past(pin_input_value[7]);
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input register read wrong");

  property p_alt_override;
    @(posedge hclk) disable iff (!hresetn)
    pin7_role_select && pin_direction[7] |=> pin_oe[7];
  endproperty
  a_alt_override: assert property (p_alt_override)
    else $error("direction bit overrode pin 7 role");

endmodule : gpio_pin_control

// [hdl/gpio_pin_control_params.svh]
`ifndef GPIO_PIN_CONTROL_PARAMS_SVH
`define GPIO_PIN_CONTROL_PARAMS_SVH

// ***********************************************************
// Register indices (byte address is four times the index)
// ***********************************************************
`define GPC_IDX_FUNC_SEL 8'h4F
`define GPC_IDX_OUT_VAL 8'h50
`define GPC_IDX_DIRECTION 8'h51
`define GPC_IDX_IN_VAL 8'h52

// ***********************************************************
// Reset values and implemented-bit masks
// ***********************************************************
`define GPC_RST_FUNC_SEL 8'h00
`define GPC_RST_OUT_VAL 8'h00
`define GPC_RST_DIRECTION 8'hFF
`define GPC_FUNC_SEL_MASK 8'hC0
`define GPC_PIN_USABLE_MASK 8'hFD

// ***********************************************************
// Field positions and pin numbers
// ***********************************************************
`define GPC_BIT_PIN7_ROLE 7
`define GPC_BIT_PIN65_ROLE 6
`define GPC_PIN_SEVEN 7
`define GPC_PIN_SIX 6
`define GPC_PIN_FIVE 5
`define GPC_PIN_ANT_DIR 1
`define GPC_PIN_ZERO 0

// ***********************************************************
// Bus constants
// ***********************************************************
`define GPC_RDATA_ZERO 32'h0000_0000
`define GPC_TRANS_ACTIVE_BIT 1

`endif

// [hdl/gpio_pin_control_pkg.sv]
package gpio_pin_control_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_FUNC = 3'b001,
    SEL_OUT = 3'b010,
    SEL_DIR = 3'b011,
    SEL_IN = 3'b100
  } reg_sel_t;

  typedef logic [7:0] byte_reg_t;

endpackage : gpio_pin_control_pkg

// [hdl/pin_level_sync.sv]
`timescale 1ns/1ps

// ***********************************************************
// Two-stage synchroniser for asynchronous pin levels
// ***********************************************************
module pin_level_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels
  input wire logic [WIDTH-1:0] async_level,
  output logic [WIDTH-1:0] sync_level
);

  logic [WIDTH-1:0] meta_stage;

  // First stage is read only by the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_stage <= '0;
      sync_level <= '0;
    end else begin
      meta_stage <= async_level;
      sync_level <= meta_stage;
    end
  end

endmodule : pin_level_sync

// [tb/pin_board_model.sv]
`timescale 1ns/1ps

// ***********************************************************
// Board side of the pins
// ***********************************************************
module pin_board_model (
  // Device drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Levels from other board parts
  input wire logic [7:0] board_level,
  // Level seen back at the device
  output logic [7:0] pin_in
);
  // Driver wins per pin
  // A pin the device releases shows only what the board puts on it
  assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule : pin_board_model

// [tb/gpio_pin_control_tb.sv]
`timescale 1ns/1ps
`include "gpio_pin_control_params.svh"

module gpio_pin_control_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic irq, sync, ant, two, aci;
  logic [7:0] pin_in, pin_out, pin_oe, board;
  logic rd_phase;
  logic [31:0] expq[$];
  int n_mismatch, n_checks;

  assign hready = hreadyout;

  gpio_pin_control i_gpio_pin_control (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq_source(irq), .sync_source(sync), .antenna_drives_out(ant),
    .antenna_two_pin_mode(two), .antenna_control_input(aci),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  pin_board_model i_pin_board_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .board_level(board), .pin_in(pin_in));

  // Clock at 25 ns
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task close_out;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_rdy

  // One single word transfer; reads note their expected data
  task ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    haddr <= {22'h00_0000, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? {24'h00_0000, d} : 32'h0000_0000;
    if (!wr) begin
      expq.push_back({24'h00_0000, d});
    end
    wait_rdy();
  endtask : ahb

  // Watcher: read data and response in each read data phase
  always @(posedge hclk) begin
    if (rd_phase) begin
      chk(hrdata, expq.pop_front());
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
      chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
    end
    rd_phase <= hsel && hready && htrans[1] && !hwrite;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    logic [7:0] f, v, d, e, o;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {irq, sync, ant, two, board} = '0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'hc82e9dbc));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Reset state: all inputs but the antenna direction pin
    chk({24'h00_0000, pin_oe}, 32'h0000_0002);
    ahb(1'b0, `GPC_IDX_FUNC_SEL, `GPC_RST_FUNC_SEL);
    ahb(1'b0, `GPC_IDX_OUT_VAL, `GPC_RST_OUT_VAL);
    ahb(1'b0, `GPC_IDX_DIRECTION, `GPC_RST_DIRECTION);
    ahb(1'b0, 8'hA0, 8'h00);
    // Every role and pin mode combination, random levels
    for (int k = 0; k < 8; k++) begin
      f = {k[1:0], 6'h00};
      v = 8'($urandom);
      d = 8'($urandom);
      @(posedge hclk);
      {irq, sync, ant} <= 3'($urandom);
      two <= k[2];
      board <= 8'($urandom);
      ahb(1'b1, `GPC_IDX_FUNC_SEL, f | 8'($urandom % 64));
      ahb(1'b0, `GPC_IDX_FUNC_SEL, f);
      ahb(1'b1, `GPC_IDX_OUT_VAL, v);
      ahb(1'b1, `GPC_IDX_DIRECTION, d);
      ahb(1'b0, `GPC_IDX_OUT_VAL, v);
      ahb(1'b0, `GPC_IDX_DIRECTION, d);
      repeat (8) @(posedge hclk);
      e = ~d;
      o = v;
      e[1] = 1'b1;
      o[1] = ant;
      if (f[7]) begin
        e[7] = 1'b1;
        o[7] = irq;
      end
      if (f[6]) begin
        e[5] = 1'b1;
        e[6] = 1'b0;
        o[5] = sync;
      end
      if (two) begin
        e[0] = 1'b0;
      end
      chk({24'h00_0000, pin_oe}, {24'h00_0000, e});
      chk({24'h00_0000, pin_out & e}, {24'h00_0000, o & e});
      chk({31'h0000_0000, aci}, {31'h0000_0000, two & board[0]});
      ahb(1'b0, `GPC_IDX_IN_VAL, ((o & e) | (board & ~e)) & 8'hFD);
    end
    repeat (3) @(posedge hclk);
    close_out();
  end
endmodule : gpio_pin_control_tb
